// ===== inc/vgw_pkg.sv
// package: constants and types for the graphics write/read datapath
package vgw_pkg;
  localparam logic [5:0] IDX_SET_RESET = 6'h00;
  localparam logic [5:0] IDX_SR_ENABLE = 6'h01;
  localparam logic [5:0] IDX_CMP_VALUE = 6'h02;
  localparam logic [5:0] IDX_ROT_FUNC = 6'h03;
  localparam logic [5:0] IDX_PLANE_SEL = 6'h04;
  localparam logic [5:0] IDX_MODE_CTL = 6'h05;
  localparam logic [5:0] IDX_CARE_MASK = 6'h07;
  localparam logic [5:0] IDX_STD_LAST = 6'h08;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] LOW_NIBBLE = 8'h0f;
  localparam logic [5:0] INDEX_RESET = 6'h00;
  localparam int ROT_LO = 0;
  localparam int ROT_HI = 2;
  localparam int FUNC_LO = 3;
  localparam int FUNC_HI = 4;
  localparam int READ_MODE_BIT = 3;
  localparam int WMODE_LO = 0;
  localparam int WMODE_HI = 2;

  typedef enum logic [2:0] {
    VGW_WM0 = 3'b000,
    VGW_WM1 = 3'b001,
    VGW_WM2 = 3'b010,
    VGW_WM3 = 3'b011,
    VGW_WM4 = 3'b100,
    VGW_WM5 = 3'b101
  } vgw_wmode_t;

  typedef enum logic [1:0] {
    VGW_FN_NONE = 2'b00,
    VGW_FN_AND = 2'b01,
    VGW_FN_OR = 2'b10,
    VGW_FN_XOR = 2'b11
  } vgw_func_t;

  // host port access
  typedef struct packed {
    logic idx_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] wdata;
  } vgw_io_t;

  // four planes of one byte address
  typedef struct packed {
    logic [7:0] p3;
    logic [7:0] p2;
    logic [7:0] p1;
    logic [7:0] p0;
  } vgw_planes_t;

  // colour bytes presented to the expansion logic
  typedef struct packed {
    logic [7:0] bg_lo;
    logic [7:0] fg_lo;
    logic bg_valid;
    logic fg_valid;
  } vgw_colors_t;
endpackage : vgw_pkg

// ===== rtl/vgw_compare.sv
// colour compare for read mode 1
`timescale 1ns/1ps
module vgw_compare (
  input wire vgw_pkg::vgw_planes_t i_planes,
  input wire logic [3:0] i_color,
  input wire logic [3:0] i_care,
  output logic [7:0] o_match
);
  import vgw_pkg::*;
  logic [3:0] bits;
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      bits = {i_planes.p3[b], i_planes.p2[b], i_planes.p1[b], i_planes.p0[b]};
      // ignored planes always match [RL13]
      o_match[b] = &(~(bits ^ i_color) | ~i_care); // [RL12] [RL13]
    end
  end
endmodule : vgw_compare

// ===== rtl/vgw_datapath.sv
// graphics controller index/data registers and host datapath top
// Operation
// [RL1] index selects register at data port
// [RL2] index above eight reaches extension registers
// [RL3] set/reset byte is mode-5 background
// [RL4] wide colour: set/reset is background low byte
// [RL5] set/reset high nibble gated by wide bit
// [RL6] enable high nibble gated by wide bit
// [RL7] enable byte is modes 4/5 foreground
// [RL8] wide colour: enable is foreground low byte
// [RL9] write mode 0 per-plane set/reset substitution
// [RL10] disable bit suppresses set/reset substitution
// [RL11] set/reset value feeds modes 0 and 3
// [RL12] read mode 1 colour compare per bit
// [RL13] care mask zero planes always match
// [RL14] logical function only in write mode 0
// [RL15] function: none, and, or, xor
// [RL16] rotate host data right 0 to 7
// [RL17] rotation precedes all other write operations
// [RL18] rotate and function share one register
// [RL19] latches reload on every memory read
// [RL20] read mode 0 returns selected plane
// [RL21] registers reset to zero, index readback
`timescale 1ns/1ps
module vgw_datapath (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire vgw_pkg::vgw_io_t i_io,
  input wire logic i_wide_color,
  input wire logic i_sr_disable,
  input wire logic i_mem_rd,
  input wire vgw_pkg::vgw_planes_t i_mem_data,
  input wire logic i_mem_wr,
  input wire logic [7:0] i_host_wdata,
  output logic [7:0] o_rdata,
  output logic o_ext_sel,
  output logic [5:0] o_ext_index,
  output vgw_pkg::vgw_planes_t o_mem_wdata,
  output logic o_mem_we,
  output vgw_pkg::vgw_colors_t o_colors,
  output logic [7:0] o_host_rdata
);
  import vgw_pkg::*;

  logic [5:0] graphics_index_reg;
  logic [7:0] plane_set_reset_value_reg;
  logic [7:0] plane_set_reset_enable_reg;
  logic [7:0] color_compare_value_reg;
  logic [7:0] rotate_and_function_reg;
  logic [7:0] read_plane_select_reg;
  logic [7:0] graphics_mode_control_reg;
  logic [7:0] compare_care_mask_reg;
  vgw_planes_t latch_reg;
  logic [1:0] wide_sync_reg;
  logic [1:0] srd_sync_reg;
  logic wide;
  logic srd;
  logic [7:0] hi_mask;
  vgw_wmode_t wmode;
  vgw_planes_t wr_data;
  logic [7:0] match;
  logic [7:0] plane_byte;
  logic std_sel;

  // strap-like extension bits come from another block, resynchronised
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wide_sync_reg <= 2'b00;
      srd_sync_reg <= 2'b00;
    end else begin
      wide_sync_reg <= {wide_sync_reg[0], i_wide_color};
      srd_sync_reg <= {srd_sync_reg[0], i_sr_disable};
    end
  end
  assign wide = wide_sync_reg[1];
  assign srd = srd_sync_reg[1];
  // upper nibble exists only with wide colour enabled
  assign hi_mask = wide ? ~REG_RESET : LOW_NIBBLE; // [RL5] [RL6]
  assign std_sel = graphics_index_reg <= IDX_STD_LAST; // [RL2]
  assign wmode = vgw_wmode_t'(graphics_mode_control_reg[WMODE_HI:WMODE_LO]);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      graphics_index_reg <= INDEX_RESET; // [RL21]
    end else if (i_io.idx_wr) begin
      graphics_index_reg <= i_io.wdata[5:0]; // [RL1]
    end
  end

  // data port writes land on the indexed register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      plane_set_reset_value_reg <= REG_RESET; // [RL21]
      plane_set_reset_enable_reg <= REG_RESET;
      color_compare_value_reg <= REG_RESET;
      rotate_and_function_reg <= REG_RESET;
      read_plane_select_reg <= REG_RESET;
      graphics_mode_control_reg <= REG_RESET;
      compare_care_mask_reg <= REG_RESET;
    end else if (i_io.data_wr && std_sel) begin // [RL1]
      case (graphics_index_reg)
        IDX_SET_RESET: plane_set_reset_value_reg <= i_io.wdata & hi_mask; // [RL5]
        IDX_SR_ENABLE: plane_set_reset_enable_reg <= i_io.wdata & hi_mask; // [RL6]
        IDX_CMP_VALUE: color_compare_value_reg <= i_io.wdata & LOW_NIBBLE;
        IDX_ROT_FUNC: rotate_and_function_reg <= {3'h0, i_io.wdata[FUNC_HI:ROT_LO]}; // [RL18]
        IDX_PLANE_SEL: read_plane_select_reg <= {6'h00, i_io.wdata[1:0]};
        IDX_MODE_CTL: graphics_mode_control_reg <= i_io.wdata;
        IDX_CARE_MASK: compare_care_mask_reg <= i_io.wdata & LOW_NIBBLE;
        default: ;
      endcase
    end
  end

  // register readback and extension forwarding
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rdata <= REG_RESET;
      o_ext_sel <= 1'b0;
      o_ext_index <= INDEX_RESET;
    end else begin
      o_ext_index <= graphics_index_reg;
      o_ext_sel <= !std_sel && (i_io.data_wr || i_io.data_rd); // [RL2]
      if (i_io.data_rd && std_sel) begin
        case (graphics_index_reg)
          // stored high nibble hidden while wide colour is off
          IDX_SET_RESET: o_rdata <= plane_set_reset_value_reg & hi_mask; // [RL5]
          IDX_SR_ENABLE: o_rdata <= plane_set_reset_enable_reg & hi_mask; // [RL6]
          IDX_CMP_VALUE: o_rdata <= color_compare_value_reg;
          IDX_ROT_FUNC: o_rdata <= rotate_and_function_reg;
          IDX_PLANE_SEL: o_rdata <= read_plane_select_reg;
          IDX_MODE_CTL: o_rdata <= graphics_mode_control_reg;
          IDX_CARE_MASK: o_rdata <= compare_care_mask_reg;
          default: o_rdata <= REG_RESET;
        endcase
      end else if (i_io.idx_wr) begin
        o_rdata <= o_rdata;
      end else if (!i_io.data_rd) begin
        o_rdata <= {2'b00, graphics_index_reg}; // [RL21]
      end
    end
  end

  // latches follow every display memory read
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      latch_reg <= '0;
    end else if (i_mem_rd) begin
      latch_reg <= i_mem_data; // [RL19]
    end
  end

  vgw_write_path u_write (
    .i_host(i_host_wdata),
    .i_rot(rotate_and_function_reg[ROT_HI:ROT_LO]),
    .i_func(vgw_func_t'(rotate_and_function_reg[FUNC_HI:FUNC_LO])),
    .i_wmode(wmode),
    .i_sr_disable(srd),
    .i_sr_value(plane_set_reset_value_reg[3:0]),
    .i_sr_enable(plane_set_reset_enable_reg[3:0]),
    .i_latch(latch_reg),
    .o_data(wr_data)
  );

  vgw_compare u_cmp (
    .i_planes(i_mem_data),
    .i_color(color_compare_value_reg[3:0]),
    .i_care(compare_care_mask_reg[3:0]),
    .o_match(match)
  );

  always_comb begin
    case (read_plane_select_reg[1:0])
      2'h0: plane_byte = i_mem_data.p0;
      2'h1: plane_byte = i_mem_data.p1;
      2'h2: plane_byte = i_mem_data.p2;
      default: plane_byte = i_mem_data.p3;
    endcase
  end

  // memory read result registered with the host read
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_host_rdata <= REG_RESET;
    end else if (i_mem_rd) begin
      if (graphics_mode_control_reg[READ_MODE_BIT]) begin
        o_host_rdata <= match; // [RL12]
      end else begin
        o_host_rdata <= plane_byte; // [RL20]
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_mem_wdata <= '0;
      o_mem_we <= 1'b0;
    end else begin
      o_mem_we <= i_mem_wr;
      if (i_mem_wr) begin
        o_mem_wdata <= wr_data; // [RL9] [RL17]
      end
    end
  end

  // colour bytes for the expansion engine
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_colors <= '0;
    end else begin
      o_colors.bg_lo <= plane_set_reset_value_reg & hi_mask; // [RL3] [RL4]
      o_colors.fg_lo <= plane_set_reset_enable_reg & hi_mask; // [RL7] [RL8]
      o_colors.bg_valid <= (wmode == VGW_WM5); // [RL3]
      o_colors.fg_valid <= (wmode == VGW_WM4) || (wmode == VGW_WM5); // [RL7]
    end
  end

  property p_index_load;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_io.idx_wr |=> graphics_index_reg == $past(i_io.wdata[5:0]);
  endproperty
  a_index_load: assert property (p_index_load) else $error("index not loaded"); // [RL1]

  property p_ext_sel;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_io.data_rd && graphics_index_reg > IDX_STD_LAST) |=> o_ext_sel;
  endproperty
  a_ext_sel: assert property (p_ext_sel) else $error("extension not selected"); // [RL2]

  property p_hi_nibble;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !wide |-> o_colors.bg_lo[7:4] == 4'h0 || $past(wide);
  endproperty
  a_hi_nibble: assert property (p_hi_nibble) else $error("high nibble visible"); // [RL5]

  property p_latch;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_mem_rd |=> latch_reg == $past(i_mem_data);
  endproperty
  a_latch: assert property (p_latch) else $error("latch not reloaded"); // [RL19]

  sequence s_mode0_read;
    i_mem_rd && !graphics_mode_control_reg[READ_MODE_BIT];
  endsequence
  property p_read0;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      s_mode0_read |=> o_host_rdata == $past(plane_byte);
  endproperty
  a_read0: assert property (p_read0) else $error("read mode 0 wrong"); // [RL20]

  property p_read1;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_mem_rd && graphics_mode_control_reg[READ_MODE_BIT]
       && compare_care_mask_reg[3:0] == 4'h0) |=> o_host_rdata == 8'hff;
  endproperty
  a_read1: assert property (p_read1) else $error("masked compare not all ones"); // [RL13]

  property p_nofunc_wm3;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_mem_wr && wmode == VGW_WM3) |=> o_mem_wdata.p0 == {8{$past(plane_set_reset_value_reg[0])}};
  endproperty
  a_nofunc_wm3: assert property (p_nofunc_wm3) else $error("mode 3 plane data wrong"); // [RL11]

  property p_we;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_mem_wr |=> o_mem_we ##1 (o_mem_we == $past(i_mem_wr));
  endproperty
  a_we: assert property (p_we) else $error("write strobe lost"); // [RL17]

  sequence s_index_write;
    i_io.idx_wr;
  endsequence
  property p_ext_track;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      s_index_write |=> ##1 o_ext_index == $past(i_io.wdata[5:0], 2);
  endproperty
  a_ext_track: assert property (p_ext_track) else $error("index not forwarded"); // [RL1]

  property p_idx_readback;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (!i_io.idx_wr && !i_io.data_rd) |=> o_rdata == {2'h0, $past(graphics_index_reg)};
  endproperty
  a_idx_readback: assert property (p_idx_readback) else $error("index readback wrong"); // [RL21]

  property p_mask_write;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_io.data_wr && graphics_index_reg == IDX_SET_RESET && !wide)
        |=> plane_set_reset_value_reg[7:4] == 4'h0;
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("high nibble stored"); // [RL5]

  property p_mask_read;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_io.data_rd && graphics_index_reg <= IDX_SR_ENABLE && !wide)
        |=> o_rdata[7:4] == 4'h0;
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("high nibble read"); // [RL5] [RL6]

  property p_bg_narrow;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !wide |=> o_colors.bg_lo == {4'h0, $past(plane_set_reset_value_reg[3:0])};
  endproperty
  a_bg_narrow: assert property (p_bg_narrow) else $error("narrow background wrong"); // [RL3]

  property p_bg_wide;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      wide |=> o_colors.bg_lo == $past(plane_set_reset_value_reg);
  endproperty
  a_bg_wide: assert property (p_bg_wide) else $error("wide background wrong"); // [RL4]

  property p_fg_wide;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      wide |=> o_colors.fg_lo == $past(plane_set_reset_enable_reg);
  endproperty
  a_fg_wide: assert property (p_fg_wide) else $error("wide foreground wrong"); // [RL8]

  property p_fg4;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (wmode == VGW_WM4) |=> o_colors.fg_valid && !o_colors.bg_valid;
  endproperty
  a_fg4: assert property (p_fg4) else $error("mode 4 colour flags wrong"); // [RL7]

  property p_mode0_sr;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_mem_wr && wmode == VGW_WM0 && !srd && plane_set_reset_enable_reg[0]
       && rotate_and_function_reg[FUNC_HI:FUNC_LO] == 2'h0)
        |=> o_mem_wdata.p0 == {8{$past(plane_set_reset_value_reg[0])}};
  endproperty
  a_mode0_sr: assert property (p_mode0_sr) else $error("set/reset not substituted"); // [RL9]

  property p_srd;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_mem_wr && wmode == VGW_WM0 && srd && rotate_and_function_reg[FUNC_HI:ROT_LO] == 5'h00)
        |=> o_mem_wdata.p0 == $past(i_host_wdata);
  endproperty
  a_srd: assert property (p_srd) else $error("disabled set/reset still applied"); // [RL10]

  property p_rot7;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_mem_wr && wmode == VGW_WM0 && !plane_set_reset_enable_reg[1]
       && rotate_and_function_reg[FUNC_HI:ROT_LO] == 5'h07)
        |=> o_mem_wdata.p1 == $past({i_host_wdata[6:0], i_host_wdata[7]});
  endproperty
  a_rot7: assert property (p_rot7) else $error("rotate by seven wrong"); // [RL16]

  property p_func_and;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_mem_wr && wmode == VGW_WM0 && plane_set_reset_enable_reg[3:0] == 4'h0
       && rotate_and_function_reg[FUNC_HI:ROT_LO] == 5'h08)
        |=> o_mem_wdata == $past(latch_reg & {4{i_host_wdata}});
  endproperty
  a_func_and: assert property (p_func_and) else $error("and with latches wrong"); // [RL15]

  property p_rot_reg;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_io.data_wr && graphics_index_reg == IDX_ROT_FUNC)
        |=> rotate_and_function_reg[FUNC_HI:ROT_LO] == $past(i_io.wdata[FUNC_HI:ROT_LO]);
  endproperty
  a_rot_reg: assert property (p_rot_reg) else $error("rotate register not loaded"); // [RL18]

  // no disable here, so the reset edges themselves are watched
  property p_reset_regs;
    @(posedge i_sys_clk)
      !i_rst_n |=> graphics_index_reg == INDEX_RESET && plane_set_reset_value_reg == REG_RESET
        && rotate_and_function_reg == REG_RESET && o_host_rdata == REG_RESET;
  endproperty
  a_reset_regs: assert property (p_reset_regs) else $error("register not cleared"); // [RL21]
endmodule : vgw_datapath

// ===== rtl/vgw_write_path.sv
// write-path datapath: rotate, set/reset, logical function
`timescale 1ns/1ps
module vgw_write_path (
  input wire logic [7:0] i_host,
  input wire logic [2:0] i_rot,
  input wire vgw_pkg::vgw_func_t i_func,
  input wire vgw_pkg::vgw_wmode_t i_wmode,
  input wire logic i_sr_disable,
  input wire logic [3:0] i_sr_value,
  input wire logic [3:0] i_sr_enable,
  input wire vgw_pkg::vgw_planes_t i_latch,
  output vgw_pkg::vgw_planes_t o_data
);
  import vgw_pkg::*;

  function automatic logic [7:0] rotr(input logic [7:0] d, input logic [2:0] n);
    logic [15:0] w;
    w = {d, d} >> n;
    return w[7:0];
  endfunction : rotr

  function automatic logic [7:0] alu(input logic [7:0] a, input logic [7:0] l,
                                     input vgw_func_t f);
    case (f)
      VGW_FN_AND: alu = a & l;
      VGW_FN_OR: alu = a | l;
      VGW_FN_XOR: alu = a ^ l;
      default: alu = a;
    endcase
  endfunction : alu

  logic [7:0] rot;
  logic [7:0] src [4];
  logic [7:0] lat [4];
  logic [7:0] res [4];
  assign rot = rotr(i_host, i_rot); // rotation first [RL16] [RL17]
  assign lat[0] = i_latch.p0;
  assign lat[1] = i_latch.p1;
  assign lat[2] = i_latch.p2;
  assign lat[3] = i_latch.p3;

  always_comb begin
    for (int p = 0; p < 4; p++) begin
      src[p] = rot;
      res[p] = rot;
      if (i_wmode == VGW_WM3) begin
        // set/reset value is the plane data in mode 3 [RL11]
        src[p] = {8{i_sr_value[p]}};
        res[p] = src[p];
      end else if (i_wmode == VGW_WM0) begin
        if (!i_sr_disable && i_sr_enable[p]) begin // [RL9] [RL10]
          src[p] = {8{i_sr_value[p]}}; // [RL11]
        end
        res[p] = alu(src[p], lat[p], i_func); // function only in mode 0 [RL14] [RL15]
      end
    end
  end
  assign o_data = {res[3], res[2], res[1], res[0]};
endmodule : vgw_write_path

// ===== verification/tb_top.sv
// self-checking bench for the graphics write/read datapath
`timescale 1ns/1ps
module tb_top;
  import vgw_pkg::*;
  logic clk;
  logic rst_n;
  vgw_io_t io;
  logic wide;
  logic sr_dis;
  logic mem_rd;
  logic mem_wr;
  logic [7:0] hw;
  logic preset;
  vgw_planes_t pre_d;
  vgw_planes_t mem_data;
  logic [7:0] rdata;
  logic ext_sel;
  logic [5:0] ext_index;
  vgw_planes_t mem_wdata;
  logic mem_we;
  vgw_colors_t colors;
  logic [7:0] host_rdata;
  logic [7:0] v;
  int miscompares;
  int total_checks;
  int cycles;

  vgw_datapath vgw_datapath_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_io(io),
    .i_wide_color(wide), .i_sr_disable(sr_dis), .i_mem_rd(mem_rd), .i_mem_data(mem_data),
    .i_mem_wr(mem_wr), .i_host_wdata(hw), .o_rdata(rdata), .o_ext_sel(ext_sel),
    .o_ext_index(ext_index), .o_mem_wdata(mem_wdata), .o_mem_we(mem_we),
    .o_colors(colors), .o_host_rdata(host_rdata));
  vgw_mem_model vgw_mem_model_inst (.i_sys_clk(clk), .i_preset(preset),
    .i_preset_data(pre_d), .i_mem_we(mem_we), .i_mem_wdata(mem_wdata), .o_mem_data(mem_data));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic io_op(input logic iw, input logic dw, input logic dr, input logic [7:0] d);
    @(posedge clk);
    io <= '{idx_wr: iw, data_wr: dw, data_rd: dr, wdata: d};
  endtask : io_op

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    io_op(1'b1, 1'b0, 1'b0, idx);
    io_op(1'b0, 1'b1, 1'b0, d);
    io_op(1'b0, 1'b0, 1'b0, 8'h00);
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d);
    io_op(1'b1, 1'b0, 1'b0, idx);
    io_op(1'b0, 1'b0, 1'b1, 8'h00);
    io_op(1'b0, 1'b0, 1'b0, 8'h00);
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic settle(input logic w, input logic s);
    @(posedge clk);
    wide <= w;
    sr_dis <= s;
    // level inputs pass a two-flop synchroniser
    repeat (4) @(posedge clk);
  endtask : settle

  task automatic mem_op(input logic r, input logic [7:0] d);
    @(posedge clk);
    mem_rd <= r;
    mem_wr <= ~r;
    hw <= d;
    @(posedge clk);
    mem_rd <= 1'b0;
    mem_wr <= 1'b0;
    #1;
  endtask : mem_op

  task automatic mem_wr_chk(input logic [7:0] d, input logic [31:0] exp);
    mem_op(1'b0, d);
    chk(mem_we, 1'b1, "write strobe");
    chk(mem_wdata, exp, "plane data");
    @(posedge clk);
    #1;
    chk(mem_we, 1'b0, "strobe one cycle");
  endtask : mem_wr_chk

  task automatic load_planes(input logic [31:0] d);
    @(posedge clk);
    preset <= 1'b1;
    pre_d <= d;
    @(posedge clk);
    preset <= 1'b0;
    mem_op(1'b1, 8'h00);
  endtask : load_planes

  task automatic t_reset_index();
    for (int i = 0; i <= 8; i++) begin
      rd_reg(i[7:0], v);
      chk(v, 8'h00, "reset value");
    end
    io_op(1'b1, 1'b0, 1'b0, 8'hff);
    io_op(1'b0, 1'b0, 1'b0, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk(rdata, 8'h3f, "index readback");
    chk(ext_index, 6'h3f, "index out");
    wr_reg(8'h09, 8'h55);
    chk(ext_sel, 1'b1, "ext hit");
    wr_reg(8'h08, 8'h55);
    chk(ext_sel, 1'b0, "std hit");
  endtask : t_reset_index

  task automatic t_nibble_colors();
    settle(1'b0, 1'b0);
    wr_reg(8'h00, 8'hff);
    wr_reg(8'h01, 8'hff);
    wr_reg(8'h03, 8'h1b);
    rd_reg(8'h00, v);
    chk(v, 8'h0f, "value nibble off");
    rd_reg(8'h01, v);
    chk(v, 8'h0f, "enable nibble off");
    rd_reg(8'h03, v);
    chk(v, 8'h1b, "rotate reg");
    settle(1'b1, 1'b0);
    wr_reg(8'h00, 8'ha5);
    wr_reg(8'h01, 8'h5a);
    rd_reg(8'h00, v);
    chk(v, 8'ha5, "value nibble on");
    rd_reg(8'h01, v);
    chk(v, 8'h5a, "enable nibble on");
    wr_reg(8'h05, 8'h05);
    repeat (2) @(posedge clk);
    #1;
    chk(colors, {8'ha5, 8'h5a, 2'b11}, "mode5 colours");
    wr_reg(8'h05, 8'h04);
    repeat (2) @(posedge clk);
    #1;
    chk({colors.fg_lo, colors.bg_valid, colors.fg_valid}, {8'h5a, 2'b01}, "mode4");
    settle(1'b0, 1'b0);
    wr_reg(8'h05, 8'h05);
    wr_reg(8'h00, 8'h03);
    wr_reg(8'h01, 8'h0c);
    repeat (2) @(posedge clk);
    #1;
    chk(colors, {8'h03, 8'h0c, 2'b11}, "narrow colours");
    wr_reg(8'h05, 8'h00);
  endtask : t_nibble_colors

  task automatic t_write0();
    wr_reg(8'h00, 8'h03);
    wr_reg(8'h01, 8'h05);
    wr_reg(8'h03, 8'h01);
    // rotated 0x01 -> 0x80, planes 0 and 2 substituted
    mem_wr_chk(8'h01, {8'h80, 8'h00, 8'h80, 8'hff});
    wr_reg(8'h01, 8'h00);
    wr_reg(8'h03, 8'h07);
    mem_wr_chk(8'h81, {4{8'h03}});
    settle(1'b0, 1'b1);
    wr_reg(8'h01, 8'h0f);
    wr_reg(8'h03, 8'h00);
    mem_wr_chk(8'h3c, {4{8'h3c}});
    settle(1'b0, 1'b0);
    wr_reg(8'h01, 8'h00);
  endtask : t_write0

  task automatic t_read_func();
    logic [31:0] lat;
    lat = {8'hf0, 8'hcc, 8'haa, 8'h0f};
    load_planes(lat);
    for (int p = 0; p < 4; p++) begin
      wr_reg(8'h04, p[7:0]);
      mem_op(1'b1, 8'h00);
      chk(host_rdata, lat[p*8 +: 8], "plane select");
    end
    mem_wr_chk(8'h3c, {4{8'h3c}});
    wr_reg(8'h03, 8'h08);
    mem_wr_chk(8'h3c, lat & {4{8'h3c}});
    wr_reg(8'h03, 8'h10);
    mem_wr_chk(8'h3c, lat | {4{8'h3c}});
    wr_reg(8'h03, 8'h18);
    mem_wr_chk(8'h3c, lat ^ {4{8'h3c}});
    wr_reg(8'h05, 8'h01);
    mem_wr_chk(8'h3c, {4{8'h3c}});
    wr_reg(8'h05, 8'h03);
    // mode 3 plane data is set/reset value 0011, xor still selected
    mem_wr_chk(8'h3c, {8'h00, 8'h00, 8'hff, 8'hff});
    wr_reg(8'h03, 8'h00);
  endtask : t_read_func

  task automatic t_mid_reset();
    // set/reset value, compare, plane select and mode registers and the read result hold non-zero values here
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i <= 7; i++) begin
      rd_reg(i[7:0], v);
      chk(v, 8'h00, "value after reset");
    end
    chk(host_rdata, 8'h00, "read result after reset");
    chk(colors, 18'h00000, "colours after reset");
  endtask : t_mid_reset

  task automatic t_compare();
    // colour 0101: plane0 ones, plane2 ones, planes 1 and 3 zeros
    wr_reg(8'h05, 8'h08);
    wr_reg(8'h02, 8'h05);
    wr_reg(8'h07, 8'h0f);
    load_planes({8'h00, 8'h33, 8'h0f, 8'hff});
    chk(host_rdata, 8'h30, "compare all");
    wr_reg(8'h07, 8'h02);
    mem_op(1'b1, 8'h00);
    chk(host_rdata, 8'hf0, "care plane1");
    wr_reg(8'h07, 8'h00);
    mem_op(1'b1, 8'h00);
    chk(host_rdata, 8'hff, "care none");
  endtask : t_compare

  initial begin
    rst_n = 1'b0;
    io = '0;
    wide = 1'b0;
    sr_dis = 1'b0;
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    hw = 8'h00;
    preset = 1'b0;
    pre_d = '0;
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_index();
    t_nibble_colors();
    t_write0();
    t_read_func();
    t_compare();
    t_mid_reset();
    end_of_test();
  end
endmodule : tb_top

// ===== verification/vgw_mem_model.sv
// display memory partner: four plane bytes at one address
`timescale 1ns/1ps
module vgw_mem_model (
  input wire logic i_sys_clk,
  input wire logic i_preset,
  input wire vgw_pkg::vgw_planes_t i_preset_data,
  input wire logic i_mem_we,
  input wire vgw_pkg::vgw_planes_t i_mem_wdata,
  output vgw_pkg::vgw_planes_t o_mem_data
);
  import vgw_pkg::*;
  vgw_planes_t store_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_preset) begin
      store_reg <= i_preset_data;
    end else if (i_mem_we) begin
      store_reg <= i_mem_wdata;
    end
  end
  // always driven, so a read sees data in its own cycle
  assign o_mem_data = store_reg;
endmodule : vgw_mem_model
